/* File: rtl/apc_top.sv */
// Converter primary control: register, run state and trigger selection
// Operation
// R1: Converter runs while converter_on is set, otherwise it is off.
// R2: With idle_stop set, conversion halts during Idle; else continues.
// R3: dma_buffer_mode picks destination-register addressing over peripheral-indirect addressing.
// R4: extended_buffer_enable turns the extended buffer features on or off.
// R5: resolution_select chooses 12-bit when set, 10-bit when clear.
// R6: trigger_source_select chooses the start source; 0101, 0110, 0111 defined.
// R7: Code 0101 uses Timer1 but never triggers during Sleep.
// R8: With the converter off, every trigger is ignored.
`timescale 1ns/1ps
`default_nettype none
module apc_top #(
  parameter int AUTO_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Power state and trigger sources
  input wire logic idle_i,
  input wire logic sleep_i,
  input wire logic sw_trig_i,
  input wire logic ext_trig_i,
  input wire logic tmr3_trig_i,
  input wire logic ctmu_trig_i,
  input wire logic tmr1_trig_i,
  // Converter controls
  output logic conv_enable_o,
  output logic conv_start_o,
  output logic res12_o,
  output logic dma_dest_mode_o,
  output logic ext_buf_en_o,
  output apc_pkg::apc_cfg_t cfg_o
);
  import apc_pkg::*;

  // Refuse interval counter widths the logic cannot serve
  if (AUTO_W < 8 || AUTO_W > 16) begin : g_bad_auto_w
    $error("AUTO_W out of range");
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [31:0] starts_r;
  apc_state_t state_r;
  apc_state_t state_nxt;
  logic [AUTO_W-1:0] auto_r;
  logic req;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wb_sel_i[0]) begin
      ctrl_nxt[7:0] = (ctrl_r[7:0] & ~APC_CTRL_WMASK[7:0]) |
                      (wb_dat_i[7:0] & APC_CTRL_WMASK[7:0]);
    end
    if (wb_sel_i[1]) begin
      ctrl_nxt[15:8] = (ctrl_r[15:8] & ~APC_CTRL_WMASK[15:8]) |
                       (wb_dat_i[15:8] & APC_CTRL_WMASK[15:8]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= APC_CTRL_RST;
    end else if (ce_i && req && wb_we_i && wb_adr_i == APC_CTRL_OFS) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        if (wb_adr_i == APC_CTRL_OFS) begin
          wb_dat_o <= {16'h0000, ctrl_r};
        end else if (wb_adr_i == APC_STAT_OFS) begin
          wb_dat_o <= {30'h0000_0000, state_r};
        end else if (wb_adr_i == APC_MODE_OFS) begin
          wb_dat_o <= starts_r;
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Run state
  // ---------------------------------------------------------------
  always_comb begin
    case (1'b1)
      !ctrl_r[APC_ON_BIT]: state_nxt = APC_OFF; // [R1]
      idle_i && ctrl_r[APC_IDLE_BIT]: state_nxt = APC_HALT; // [R2]
      default: state_nxt = APC_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= APC_OFF;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Trigger selection
  // ---------------------------------------------------------------
  logic [3:0] trig_sel;
  logic trig_hit;
  logic auto_hit;
  logic start_ok;

  assign trig_sel = ctrl_r[APC_TRIG_LO +: 4];
  // Gate on the control bit too, so the cycle after switch-off cannot start
  assign start_ok = state_r == APC_RUN && ctrl_r[APC_ON_BIT];
  assign auto_hit = auto_r == AUTO_W'(APC_AUTO_CNT);

  always_comb begin
    case (trig_sel)
      APC_TRG_SW: trig_hit = sw_trig_i;
      APC_TRG_EXT: trig_hit = ext_trig_i;
      APC_TRG_TMR3: trig_hit = tmr3_trig_i;
      APC_TRG_CTMU: trig_hit = ctmu_trig_i;
      APC_TRG_T1: trig_hit = tmr1_trig_i && !sleep_i; // [R6] [R7]
      APC_TRG_T1_SLP: trig_hit = tmr1_trig_i; // [R6]
      APC_TRG_AUTO: trig_hit = auto_hit; // [R6]
      default: trig_hit = 1'b0;
    endcase
  end

  // Auto-convert interval counter, cleared whenever it cannot fire
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_r <= '0;
    end else if (ce_i) begin
      if (state_r != APC_RUN || trig_sel != APC_TRG_AUTO || auto_hit) begin
        auto_r <= '0;
      end else begin
        auto_r <= auto_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_start_o <= 1'b0;
    end else if (ce_i) begin
      conv_start_o <= trig_hit && start_ok; // [R8] [R2]
    end
  end

  // Start counter, readable over the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      starts_r <= 32'h0000_0000;
    end else if (ce_i && trig_hit && start_ok) begin
      starts_r <= starts_r + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_enable_o <= 1'b0;
      res12_o <= 1'b0;
      dma_dest_mode_o <= 1'b0;
      ext_buf_en_o <= 1'b0;
      cfg_o <= '0;
    end else if (ce_i) begin
      conv_enable_o <= state_nxt == APC_RUN; // [R1] [R2]
      res12_o <= ctrl_r[APC_RES_BIT]; // [R5]
      dma_dest_mode_o <= ctrl_r[APC_DMA_BUFFER_MODE_BIT]; // [R3]
      ext_buf_en_o <= ctrl_r[APC_EXT_BIT]; // [R4]
      cfg_o <= '{on: ctrl_r[APC_ON_BIT], idle_stop: ctrl_r[APC_IDLE_BIT],
                 dma_mode: ctrl_r[APC_DMA_BUFFER_MODE_BIT], ext_en: ctrl_r[APC_EXT_BIT],
                 res12: ctrl_r[APC_RES_BIT], trig: trig_sel};
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_off_no_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    (ce_i && !ctrl_r[APC_ON_BIT]) |=> !conv_start_o)
    else $error("start while converter off");
  a_enable_follows_on: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (ce_i && !ctrl_r[APC_ON_BIT]) |=> !conv_enable_o)
    else $error("enable while off");
  a_idle_halts: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (ce_i && ctrl_r[APC_ON_BIT] && idle_i && ctrl_r[APC_IDLE_BIT]) |=> !conv_enable_o)
    else $error("not halted in idle");
  a_idle_runs: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (ce_i && ctrl_r[APC_ON_BIT] && !ctrl_r[APC_IDLE_BIT]) |=> conv_enable_o)
    else $error("stopped without idle stop");
  a_dma_mode: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    ce_i |=> dma_dest_mode_o == $past(ctrl_r[APC_DMA_BUFFER_MODE_BIT]))
    else $error("buffer mode mismatch");
  a_ext_buf: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    ce_i |=> ext_buf_en_o == $past(ctrl_r[APC_EXT_BIT]))
    else $error("extended buffer mismatch");
  a_res_sel: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    ce_i |=> res12_o == $past(ctrl_r[APC_RES_BIT]))
    else $error("resolution mismatch");
  a_t1_sleep: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    (ce_i && trig_sel == APC_TRG_T1 && sleep_i) |=> !conv_start_o)
    else $error("timer1 fired in sleep");
  a_t1_slp_ok: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (ce_i && start_ok && trig_sel == APC_TRG_T1_SLP && tmr1_trig_i)
    |=> conv_start_o)
    else $error("timer1 sleep trigger lost");

  // ---------------------------------------------------------------
  // Bus, state and trigger checks
  // ---------------------------------------------------------------
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (ce_i && req) |=> wb_ack_o)
    else $error("request not acknowledged");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (ce_i && wb_ack_o) |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (ce_i && req && wb_we_i && wb_adr_i == APC_CTRL_OFS && wb_sel_i[1:0] == 2'b11)
    |=> {16'h0000, ctrl_r} == ($past(wb_dat_i) & {16'h0000, APC_CTRL_WMASK}))
    else $error("control write lost");

  a_ctrl_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    !(ce_i && req && wb_we_i && wb_adr_i == APC_CTRL_OFS) |=> $stable(ctrl_r))
    else $error("control changed without write");

  a_read_ctrl: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (ce_i && req && !wb_we_i && wb_adr_i == APC_CTRL_OFS)
    |=> wb_dat_o == {16'h0000, $past(ctrl_r)})
    else $error("control read mismatch");

  a_read_state: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (ce_i && req && !wb_we_i && wb_adr_i == APC_STAT_OFS)
    |=> wb_dat_o == {30'h0000_0000, $past(state_r)})
    else $error("status read mismatch");

  a_off_state: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (ce_i && !ctrl_r[APC_ON_BIT]) |=> state_r == APC_OFF)
    else $error("state not off");

  a_halt_state: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (ce_i && ctrl_r[APC_ON_BIT] && idle_i && ctrl_r[APC_IDLE_BIT]) |=> state_r == APC_HALT)
    else $error("state not halted in idle");

  a_halt_no_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (ce_i && state_r == APC_HALT) |=> !conv_start_o)
    else $error("start while halted");

  a_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    !ce_i |=> $stable(state_r) && $stable(ctrl_r) && $stable(conv_start_o))
    else $error("state moved while clock enable low");

  a_sw_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (ce_i && start_ok && trig_sel == APC_TRG_SW && sw_trig_i) |=> conv_start_o)
    else $error("software trigger lost");

  a_ext_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (ce_i && start_ok && trig_sel == APC_TRG_EXT && ext_trig_i) |=> conv_start_o)
    else $error("external trigger lost");

  a_tmr3_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (ce_i && start_ok && trig_sel == APC_TRG_TMR3 && tmr3_trig_i) |=> conv_start_o)
    else $error("timer3 trigger lost");

  a_ctmu_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (ce_i && start_ok && trig_sel == APC_TRG_CTMU && ctmu_trig_i) |=> conv_start_o)
    else $error("charge unit trigger lost");

  a_t1_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    (ce_i && start_ok && trig_sel == APC_TRG_T1 && tmr1_trig_i && !sleep_i)
    |=> conv_start_o)
    else $error("timer1 trigger lost while awake");

  a_auto_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (ce_i && start_ok && trig_sel == APC_TRG_AUTO && auto_hit) |=> conv_start_o)
    else $error("auto conversion lost");

  a_unused_code: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (ce_i && (trig_sel == 4'h3 || trig_sel[3])) |=> !conv_start_o)
    else $error("start from unused trigger code");

  a_start_count: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (ce_i && start_ok && trig_hit) |=> starts_r == $past(starts_r) + 32'h0000_0001)
    else $error("start counter did not advance");

  a_cfg_copy: assert property (@(posedge clk_i) disable iff (rst_i) // [R1] [R6]
    ce_i |=> cfg_o.on == $past(ctrl_r[APC_ON_BIT]) && cfg_o.trig == $past(trig_sel))
    else $error("configuration copy mismatch");
endmodule
`default_nettype wire

/* File: rtl/apc_pkg.sv */
// Package for the converter primary control block
package apc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] APC_CTRL_OFS = 4'h0;
  localparam logic [3:0] APC_STAT_OFS = 4'h4;
  localparam logic [3:0] APC_MODE_OFS = 4'h8;
  localparam logic [15:0] APC_CTRL_RST = 16'h0000;
  localparam logic [15:0] APC_CTRL_WMASK = 16'hbff4;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int APC_ON_BIT = 15;
  localparam int APC_IDLE_BIT = 13;
  localparam int APC_DMA_BUFFER_MODE_BIT = 12;
  localparam int APC_EXT_BIT = 11;
  localparam int APC_RES_BIT = 10;
  localparam int APC_TRIG_LO = 4;
  localparam int APC_AUTO_BIT = 2;
  // ---------------------------------------------------------------
  // Trigger codes
  // ---------------------------------------------------------------
  localparam logic [3:0] APC_TRG_SW = 4'h0;
  localparam logic [3:0] APC_TRG_EXT = 4'h1;
  localparam logic [3:0] APC_TRG_TMR3 = 4'h2;
  localparam logic [3:0] APC_TRG_CTMU = 4'h4;
  localparam logic [3:0] APC_TRG_T1 = 4'h5;
  localparam logic [3:0] APC_TRG_T1_SLP = 4'h6;
  localparam logic [3:0] APC_TRG_AUTO = 4'h7;
  localparam logic [7:0] APC_AUTO_CNT = 8'h0f;

  typedef enum logic [1:0] {
    APC_OFF = 2'b00,
    APC_RUN = 2'b01,
    APC_HALT = 2'b10
  } apc_state_t;

  typedef struct packed {
    logic on;
    logic idle_stop;
    logic dma_mode;
    logic ext_en;
    logic res12;
    logic [3:0] trig;
  } apc_cfg_t;
endpackage

/* File: verif/apc_src_model.sv */
// Trigger source model: one-cycle pulse on the selected source line
`timescale 1ns/1ps
`default_nettype none
module apc_src_model (
  // Clock
  input wire logic clk_i,
  // Pulse request
  input wire logic [2:0] sel_i,
  input wire logic go_i,
  // Trigger lines: sw, ext, tmr3, ctmu, tmr1
  output logic [4:0] trig_o
);
  always @(posedge clk_i) begin
    trig_o <= go_i ? (5'h01 << sel_i) : 5'h00;
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking testbench for the converter primary control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import apc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, idle = 0, slp = 0, go = 0, ce = 1;
  logic [3:0] adr = 4'h0;
  logic [31:0] dw = 32'h0, dr, rv;
  logic [2:0] psel = 3'h0;
  logic [4:0] trg;
  logic ack, en, st, r12, dm, eb;
  apc_cfg_t cfg;
  int n_mismatch = 0, samples_checked = 0, n_st = 0, b;
  // Written value, expected read-back
  logic [31:0] rows [0:4][0:1] = '{'{32'hffffffff, 32'h0000bff4}, '{32'h0, 32'h0},
    '{32'h8400, 32'h8400}, '{32'h1800, 32'h1800}, '{32'h8070, 32'h8070}};
  apc_src_model i_src (.clk_i(clk_i), .sel_i(psel), .go_i(go), .trig_o(trg));
  apc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .idle_i(idle), .sleep_i(slp), .sw_trig_i(trg[0]), .ext_trig_i(trg[1]),
    .tmr3_trig_i(trg[2]), .ctmu_trig_i(trg[3]), .tmr1_trig_i(trg[4]), .conv_enable_o(en),
    .conv_start_o(st), .res12_o(r12), .dma_dest_mode_o(dm), .ext_buf_en_o(eb), .cfg_o(cfg));
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (st === 1'b1) n_st <= n_st + 1;
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; dw <= d;
    i = 0;
    do begin @(posedge clk_i); i++; end while (ack !== 1'b1 && i < 50);
    if (i >= 50) n_mismatch++;
    rv = dr;
    cyc <= 1'b0; we <= 1'b0;
  endtask
  task automatic tr(input logic [15:0] c, input logic [2:0] s, input logic sl, input int e);
    bus(1'b1, 4'h0, {16'h0, c});
    slp <= sl;
    repeat (3) @(posedge clk_i);
    b = n_st;
    go <= 1'b1; psel <= s;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (4) @(posedge clk_i);
    cmp(n_st - b, e);
  endtask
  task automatic summarize;
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    cmp(rv, 32'h0);
    cmp({31'h0, en}, 32'h0);
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 4'h0, rows[k][0]);
      bus(1'b0, 4'h0, 32'h0);
      cmp(rv, rows[k][1]);
      repeat (3) @(posedge clk_i);
      cmp({en, r12, dm, eb, cfg}, {rows[k][1][15], rows[k][1][10], rows[k][1][12],
        rows[k][1][11], rows[k][1][15], rows[k][1][13], rows[k][1][12:10],
        rows[k][1][7:4]});
    end
    tr(16'h8000, 3'd0, 1'b0, 1);
    tr(16'h8010, 3'd1, 1'b0, 1);
    tr(16'h8020, 3'd2, 1'b0, 1);
    tr(16'h8040, 3'd3, 1'b0, 1);
    tr(16'h8050, 3'd4, 1'b0, 1);
    tr(16'h8050, 3'd4, 1'b1, 0);
    tr(16'h8060, 3'd4, 1'b1, 1);
    tr(16'h8020, 3'd1, 1'b0, 0);
    tr(16'h0050, 3'd4, 1'b0, 0);
    slp <= 1'b0;
    bus(1'b1, 4'h0, 32'h8070);
    repeat (4) @(posedge clk_i);
    b = n_st;
    repeat (64) @(posedge clk_i);
    cmp(n_st - b, 4);
    bus(1'b1, 4'h0, 32'h0070);
    repeat (4) @(posedge clk_i);
    b = n_st;
    repeat (40) @(posedge clk_i);
    cmp(n_st - b, 0);
    bus(1'b1, 4'h0, 32'ha000);
    idle <= 1'b1;
    repeat (3) @(posedge clk_i);
    cmp({31'h0, en}, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    cmp(rv, 32'h2);
    bus(1'b1, 4'h0, 32'h8000);
    repeat (3) @(posedge clk_i);
    cmp({31'h0, en}, 32'h1);
    idle <= 1'b0;
    bus(1'b0, 4'hc, 32'h0);
    cmp(rv, 32'h0);
    // Clock enable low: a trigger pulse must be lost, not started
    bus(1'b1, 4'h0, 32'h8000);
    ce <= 1'b0;
    b = n_st;
    go <= 1'b1;
    psel <= 3'd0;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (4) @(posedge clk_i);
    ce <= 1'b1;
    repeat (4) @(posedge clk_i);
    cmp(n_st - b, 0);
    bus(1'b0, 4'h8, 32'h0);
    cmp(rv, 32'(n_st));
    summarize();
  end
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
